// >>> hw/pot_dev.sv
// potentiometer device end: serial slave, wipers and stored bytes
//
// Functional notes
// - write: start, id, address, data, stop; ack each
// - volatile-only write returns straight to standby
// - bus ignored, data released during store cycle
// - store cycle ends in standby awaiting start
// - control byte chooses volatile or also stored
// - master keeps write protect high to write
// - protected write: data dropped, no ack, standby
// - store needs valid bytes, exact clocks, stop
// - data bits gathered in shift register
// - locations 0,1,8 loaded on eighth falling edge
// - stop starts store for 0..6, control zero
// - read: start,id w,address,restart,id r; ack each
// - send bytes while master acks; stop ends
// - pointer starts at address, increments per byte
// - pointer wraps to zero after location 8
// - control byte picks read source for 0,1
// - id accepted on type code and select pins
// - 80h: wipers only; 00h: stored copies too
`timescale 1ns/1ps
`include "pot_link_cfg.svh"
module pot_dev
  import pot_link_pkg::*;
#(
  // device type code: value is arbitrary
  parameter logic [3:0] DEV_TYPE   = 4'h5,
  parameter int         NVW_CYCLES = `NV_WRITE_NS / `CORE_PERIOD_NS
)(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  pot_link_if.dev   link,
  input  wire logic addr_select_pin2_i,
  input  wire logic addr_select_pin1_i,
  input  wire logic addr_select_pin0_i,
  input  wire logic wr_protect_n_i,
  output byte_t     wiper0_o,
  output byte_t     wiper1_o,
  output logic      nv_busy_o
);
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] wp_sync_ff;
  logic [2:0] sel_sync0_ff;
  logic [2:0] sel_sync1_ff;
  logic       scl_prev_ff;
  logic       sda_prev_ff;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  dev_state_e state_ff;
  dev_state_e after_ack_ff;
  byte_t      shift_ff;
  logic [3:0] bit_cnt_ff;
  logic       oe_n_ff;
  logic [3:0] ptr_ff;
  logic       nv_pend_ff;
  logic       master_ack_ff;
  logic [23:0] nvw_cnt_ff;
  byte_t      wiper_ff [2];
  byte_t      store_ff [8];
  byte_t      acr_ff;

  // pins pass two flops before any logic reads them
  always_ff @(posedge core_clk_i)
  begin
    scl_sync_ff  <= {scl_sync_ff[0], link.scl};
    sda_sync_ff  <= {sda_sync_ff[0], link.sda};
    wp_sync_ff   <= {wp_sync_ff[0], wr_protect_n_i};
    sel_sync0_ff <= {addr_select_pin2_i, addr_select_pin1_i,
                     addr_select_pin0_i};
    sel_sync1_ff <= sel_sync0_ff;
    scl_prev_ff  <= scl_sync_ff[1];
    sda_prev_ff  <= sda_sync_ff[1];
  end

  assign scl_rise   = scl_sync_ff[1] && !scl_prev_ff;
  assign scl_fall   = !scl_sync_ff[1] && scl_prev_ff;
  assign start_seen = scl_sync_ff[1] && scl_prev_ff &&
                      sda_prev_ff && !sda_sync_ff[1];
  assign stop_seen  = scl_sync_ff[1] && scl_prev_ff &&
                      !sda_prev_ff && sda_sync_ff[1];

  // read source for one location
  function automatic byte_t read_loc(input logic [3:0] loc);
    byte_t v;
    v = 8'h00;
    if (loc <= `LOC_WIPER1)
      v = (acr_ff == `ACR_VOLATILE) ? wiper_ff[loc[0]] : store_ff[loc[2:0]];
    else if (loc < `LOC_ACR)
      v = store_ff[loc[2:0]];
    else if (loc == `LOC_ACR)
      v = acr_ff;
    return v;
  endfunction

  function automatic logic [3:0] next_loc(input logic [3:0] loc);
    return (loc >= `LOC_ACR) ? 4'h0 : loc + 4'h1;
  endfunction

  // protocol state machine
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_ff      <= ds_idle;
      after_ack_ff  <= ds_idle;
      shift_ff      <= 8'h00;
      bit_cnt_ff    <= 4'h0;
      oe_n_ff       <= 1'b1;
      ptr_ff        <= 4'h0;
      master_ack_ff <= 1'b0;
    end
    // nothing on the bus is seen while storing
    else if (state_ff == ds_nvwr)
    begin
      oe_n_ff <= 1'b1;
      if (nvw_cnt_ff == 24'h0)
        state_ff <= ds_idle;
    end
    else if (start_seen)
    begin
      state_ff   <= ds_id;
      bit_cnt_ff <= 4'h0;
      oe_n_ff    <= 1'b1;
    end
    else if (stop_seen)
    begin
      oe_n_ff  <= 1'b1;
      state_ff <= (state_ff == ds_wdone && nv_pend_ff) ? ds_nvwr : ds_idle;
    end
    else
    begin
      case (state_ff)
        ds_id, ds_addr, ds_wdata:
        begin
          if (scl_rise)
          begin
            shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (scl_fall && bit_cnt_ff == `BITS_PER_BYTE)
          begin
            bit_cnt_ff <= 4'h0;
            state_ff   <= ds_ack;
            oe_n_ff    <= 1'b0;
            if (state_ff == ds_id)
            begin
              after_ack_ff <= shift_ff[0] ? ds_rdata : ds_addr;
              if (shift_ff[7:1] != {DEV_TYPE, sel_sync1_ff})
              begin
                state_ff <= ds_idle;
                oe_n_ff  <= 1'b1;
              end
            end
            else if (state_ff == ds_addr)
            begin
              ptr_ff       <= shift_ff[3:0];
              after_ack_ff <= ds_wdata;
              // only locations up to 8 are valid
              if (shift_ff > {4'h0, `LOC_ACR})
              begin
                state_ff <= ds_idle;
                oe_n_ff  <= 1'b1;
              end
            end
            else
            begin
              after_ack_ff <= ds_wdone;
              if (!wp_sync_ff[1])
              begin
                state_ff <= ds_idle;
                oe_n_ff  <= 1'b1;
              end
            end
          end
        end
        ds_ack:
        begin
          if (scl_fall)
          begin
            state_ff <= after_ack_ff;
            oe_n_ff  <= 1'b1;
            if (after_ack_ff == ds_rdata)
            begin
              shift_ff <= read_loc(ptr_ff);
              oe_n_ff  <= read_loc(ptr_ff) >= 8'h80;
            end
          end
        end
        ds_rdata:
        begin
          if (scl_rise)
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt_ff == `BITS_PER_BYTE)
            begin
              bit_cnt_ff <= 4'h0;
              oe_n_ff    <= 1'b1;
              state_ff   <= ds_rack;
            end
            else
            begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              oe_n_ff  <= shift_ff[6];
            end
          end
        end
        ds_rack:
        begin
          if (scl_rise)
            master_ack_ff <= !sda_sync_ff[1];
          else if (scl_fall)
          begin
            if (master_ack_ff)
            begin
              ptr_ff   <= next_loc(ptr_ff);
              shift_ff <= read_loc(next_loc(ptr_ff));
              oe_n_ff  <= read_loc(next_loc(ptr_ff)) >= 8'h80;
              state_ff <= ds_rdata;
            end
            else
              state_ff <= ds_idle;
          end
        end
        ds_wdone:
          oe_n_ff <= 1'b1;
        ds_idle:
          oe_n_ff <= 1'b1;
        default:
        begin
          state_ff <= ds_idle;
          oe_n_ff  <= 1'b1;
        end
      endcase
    end
  end

  // volatile commit and pending store flag
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wiper_ff[0] <= `WIPER_RST;
      wiper_ff[1] <= `WIPER_RST;
      acr_ff      <= `ACR_RST;
      nv_pend_ff  <= 1'b0;
    end
    else if (state_ff == ds_wdata && scl_fall &&
             bit_cnt_ff == `BITS_PER_BYTE && wp_sync_ff[1] && !stop_seen &&
             !start_seen)
    begin
      if (ptr_ff <= `LOC_WIPER1)
        wiper_ff[ptr_ff[0]] <= shift_ff;
      else if (ptr_ff == `LOC_ACR)
        acr_ff <= shift_ff;
      nv_pend_ff <= (ptr_ff <= `LOC_LAST_NV) && (acr_ff == `ACR_RST);
    end
    // a whole extra pulse voids the store; the stop's own rise must not
    else if (state_ff == ds_wdone && scl_fall)
      nv_pend_ff <= 1'b0;
    else if (state_ff == ds_id)
      nv_pend_ff <= 1'b0;
  end

  // stored bytes and self-timed store cycle
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      store_ff   <= '{default: 8'h00};
      store_ff[0] <= `INIT_POS_RST;
      store_ff[1] <= `INIT_POS_RST;
      nvw_cnt_ff <= 24'h0;
    end
    else if (state_ff == ds_wdone && stop_seen && nv_pend_ff)
    begin
      store_ff[ptr_ff[2:0]] <= shift_ff;
      nvw_cnt_ff <= 24'(NVW_CYCLES);
    end
    else if (nvw_cnt_ff != 24'h0)
      nvw_cnt_ff <= nvw_cnt_ff - 24'h1;
  end

  assign nv_busy_o         = (state_ff == ds_nvwr);
  assign wiper0_o          = wiper_ff[0];
  assign wiper1_o          = wiper_ff[1];
  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = oe_n_ff;
endmodule

// >>> pkg/pot_link_cfg.svh
// constants for the two-wire potentiometer link
`ifndef POT_LINK_CFG_SVH
`define POT_LINK_CFG_SVH
`define LOC_WIPER0      4'h0
`define LOC_WIPER1      4'h1
`define LOC_LAST_NV     4'h6
`define LOC_ACR         4'h8
`define ACR_RST         8'h00
`define ACR_VOLATILE    8'h80
`define WIPER_RST       8'h80
`define INIT_POS_RST    8'h80
`define CORE_PERIOD_NS  40
`define NV_WRITE_NS     10000000
`define SCL_QTR_CYC     4'h4
`define BITS_PER_BYTE   4'h8
`define NVW_SLACK_CYC   8
`endif

// >>> pkg/pot_link_pkg.sv
// types shared by both ends of the potentiometer link
package pot_link_pkg;
  typedef enum logic [3:0] {
    ds_idle   = 4'h0,
    ds_id     = 4'h1,
    ds_addr   = 4'h2,
    ds_wdata  = 4'h3,
    ds_ack    = 4'h4,
    ds_wdone  = 4'h5,
    ds_rdata  = 4'h6,
    ds_rack   = 4'h7,
    ds_nvwr   = 4'h8
  } dev_state_e;

  typedef enum logic [2:0] {
    hs_idle   = 3'h0,
    hs_start  = 3'h1,
    hs_wbit   = 3'h2,
    hs_wack   = 3'h3,
    hs_rbit   = 3'h4,
    hs_rack   = 3'h5,
    hs_stop   = 3'h6,
    hs_hold   = 3'h7
  } host_state_e;

  typedef logic [7:0] byte_t;
endpackage

// >>> pkg/pot_link_if.sv
// two-wire link between host and potentiometer device
`timescale 1ns/1ps
interface pot_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // open drain: any enabled low driver pulls the line, else pulled up
  assign sda = !((!host_sda_oe_n && !host_sda_o) ||
                 (!dev_sda_oe_n && !dev_sda_o));

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );

  modport host (
    output scl,
    input  sda,
    output host_sda_o,
    output host_sda_oe_n
  );
endinterface

// >>> hw/pot_host.sv
// host end: serial master issuing single writes and sequential reads
`timescale 1ns/1ps
`include "pot_link_cfg.svh"
module pot_host
  import pot_link_pkg::*;
#(
  // device type code: value is arbitrary
  parameter logic [3:0] DEV_TYPE   = 4'h5,
  parameter int         NVW_CYCLES = `NV_WRITE_NS / `CORE_PERIOD_NS
)(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  pot_link_if.host  link,
  input  wire logic req_valid_i,
  output logic      req_ready_o,
  input  wire logic req_read_i,
  input  wire logic [2:0] req_sel_i,
  input  wire logic [3:0] req_loc_i,
  input  wire byte_t      req_data_i,
  input  wire logic [3:0] req_count_i,
  output byte_t     rd_data_o,
  output logic      rd_valid_o,
  output logic      done_o,
  output logic      nack_o
);
  host_state_e state_ff;
  logic [3:0]  qcnt_ff;
  logic [1:0]  phase_ff;
  logic        tick;
  logic        scl_ff;
  logic        sda_ff;
  logic [1:0]  sda_sync_ff;
  logic [2:0]  step_ff;
  logic [3:0]  bit_ff;
  byte_t       shift_ff;
  logic        rd_ff;
  logic [2:0]  sel_ff;
  logic [3:0]  loc_ff;
  byte_t       data_ff;
  logic [3:0]  left_ff;
  logic        nack_ff;
  logic [23:0] wait_ff;

  // quarter-bit timebase divided from the core clock
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || state_ff == hs_idle)
      qcnt_ff <= 4'h0;
    else
      qcnt_ff <= tick ? 4'h0 : qcnt_ff + 4'h1;
    sda_sync_ff <= {sda_sync_ff[0], link.sda};
  end
  assign tick = (qcnt_ff == `SCL_QTR_CYC - 4'h1);

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_ff   <= hs_idle;
      phase_ff   <= 2'h0;
      scl_ff     <= 1'b1;
      sda_ff     <= 1'b1;
      step_ff    <= 3'h0;
      bit_ff     <= 4'h0;
      shift_ff   <= 8'h00;
      rd_ff      <= 1'b0;
      sel_ff     <= 3'h0;
      loc_ff     <= 4'h0;
      data_ff    <= 8'h00;
      left_ff    <= 4'h0;
      nack_ff    <= 1'b0;
      wait_ff    <= 24'h0;
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
      case (state_ff)
        hs_idle:
          if (req_valid_i)
          begin
            rd_ff    <= req_read_i;
            sel_ff   <= req_sel_i;
            loc_ff   <= req_loc_i;
            data_ff  <= req_data_i;
            left_ff  <= (req_count_i == 4'h0) ? 4'h1 : req_count_i;
            nack_ff  <= 1'b0;
            step_ff  <= 3'h0;
            phase_ff <= 2'h0;
            state_ff <= hs_start;
          end
        hs_hold:
          if (wait_ff == 24'h0)
          begin
            state_ff <= hs_idle;
            done_o   <= 1'b1;
          end
          else
            wait_ff <= wait_ff - 24'h1;
        default:
          if (tick)
          begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0:
                case (state_ff)
                  hs_start:
                    sda_ff <= 1'b1;
                  hs_wbit:
                    sda_ff <= shift_ff[7];
                  hs_rack:
                    // ack all but the last byte
                    sda_ff <= (left_ff == 4'h1);
                  hs_stop:
                    sda_ff <= 1'b0;
                  default:
                    sda_ff <= 1'b1;
                endcase
              2'h1:
                scl_ff <= 1'b1;
              2'h2:
                case (state_ff)
                  hs_start:
                    sda_ff <= 1'b0;
                  hs_stop:
                  begin
                    sda_ff   <= 1'b1;
                    state_ff <= hs_hold;
                    // slack covers the far end's pin synchroniser delay
                    wait_ff  <= rd_ff ? 24'h0 :
                                24'(NVW_CYCLES + `NVW_SLACK_CYC);
                  end
                  hs_wack:
                    nack_ff <= sda_sync_ff[1];
                  hs_rbit:
                    shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                  default:
                    sda_ff <= sda_ff;
                endcase
              default:
              begin
                scl_ff <= 1'b0;
                bit_ff <= bit_ff + 4'h1;
                case (state_ff)
                  hs_start:
                  begin
                    shift_ff <= {DEV_TYPE, sel_ff, step_ff != 3'h0};
                    bit_ff   <= 4'h0;
                    state_ff <= hs_wbit;
                  end
                  hs_wbit:
                    if (bit_ff == `BITS_PER_BYTE - 4'h1)
                      state_ff <= hs_wack;
                    else
                      shift_ff <= {shift_ff[6:0], 1'b0};
                  hs_rbit:
                    if (bit_ff == `BITS_PER_BYTE - 4'h1)
                      state_ff <= hs_rack;
                  hs_rack:
                  begin
                    rd_data_o  <= shift_ff;
                    rd_valid_o <= 1'b1;
                    left_ff    <= left_ff - 4'h1;
                    bit_ff     <= 4'h0;
                    state_ff   <= (left_ff == 4'h1) ? hs_stop : hs_rbit;
                  end
                  hs_wack:
                  begin
                    bit_ff  <= 4'h0;
                    step_ff <= step_ff + 3'h1;
                    if (nack_ff)
                      state_ff <= hs_stop;
                    else if (step_ff == 3'h0)
                    begin
                      shift_ff <= {4'h0, loc_ff};
                      state_ff <= hs_wbit;
                    end
                    else if (step_ff == 3'h1 && !rd_ff)
                    begin
                      shift_ff <= data_ff;
                      state_ff <= hs_wbit;
                    end
                    else if (step_ff == 3'h1)
                      state_ff <= hs_start;
                    else
                      state_ff <= rd_ff ? hs_rbit : hs_stop;
                  end
                  default:
                    state_ff <= hs_stop;
                endcase
              end
            endcase
          end
      endcase
    end
  end

  assign req_ready_o        = (state_ff == hs_idle);
  assign nack_o             = nack_ff;
  assign link.scl           = scl_ff;
  assign link.host_sda_o    = 1'b0;
  // open-drain data, released for a one
  assign link.host_sda_oe_n = sda_ff;
endmodule

// >>> verif/pot_link_checker.sv
// wire-level assertions for the two-wire potentiometer link
`timescale 1ns/1ps
module pot_link_checker (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // cycles scl has stayed high; saturates so long idles stay visible
  logic [4:0] hi_cnt_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || !scl)
      hi_cnt_ff <= 5'h00;
    else if (hi_cnt_ff != 5'h1f)
      hi_cnt_ff <= hi_cnt_ff + 5'h01;
  end

  sequence scl_high_quarter;
    scl [*4];
  endsequence

  sequence scl_low_quarter;
    !scl [*4];
  endsequence

  AST_DEV_DRIVES_LOW: assert property (
    !dev_sda_oe_n |-> !dev_sda_o)
    else $error("device drives data line high");
  AST_HOST_DRIVES_LOW: assert property (
    !host_sda_oe_n |-> !host_sda_o)
    else $error("host drives data line high");
  AST_DEV_EDGE_SCL_LOW: assert property (
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device changed data line while clock high");
  AST_SCL_HIGH_MIN: assert property (
    $rose(scl) |-> scl_high_quarter)
    else $error("clock high phase shorter than a quarter");
  AST_SCL_LOW_MIN: assert property (
    $fell(scl) |-> scl_low_quarter)
    else $error("clock low phase shorter than a quarter");
  AST_DEV_RELEASE: assert property (
    $fell(dev_sda_oe_n) |-> ##[1:160] $rose(dev_sda_oe_n))
    else $error("device kept data line beyond one byte and ack");
  AST_DEV_QUIET_IDLE: assert property (
    hi_cnt_ff >= 5'h0a |-> dev_sda_oe_n)
    else $error("device drove data line during bus idle");
  AST_STOP_HOLD: assert property (
    $rose(sda) && scl && $past(scl) |-> scl_high_quarter)
    else $error("clock dropped right after stop");

  COV_DEV_ACK: cover property ($fell(dev_sda_oe_n));
endmodule

// >>> verif/dual_pot_serial_register_access_tb_top.sv
// self-checking bench: host end driving device end over the link
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) \
  begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, exp, \
  got); end end
module dual_pot_serial_register_access_tb_top
  import pot_link_pkg::*;
;
  logic       core_clk_i;
  logic       reset_i;
  logic       wr_protect_n_i;
  logic       req_valid_i;
  logic       req_read_i;
  logic [2:0] req_sel_i;
  logic [3:0] req_loc_i;
  byte_t      req_data_i;
  logic [3:0] req_count_i;
  logic       req_ready_o;
  byte_t      rd_data_o;
  logic       rd_valid_o;
  logic       done_o;
  logic       nack_o;
  byte_t      wiper0_o;
  byte_t      wiper1_o;
  logic       nv_busy_o;
  logic       saw_busy;
  byte_t      rx[$];
  int         n_mismatch;
  int         compares;
  int         cycles;
  // select straps chosen so both bits patterns 0 and 1 are present
  localparam logic [2:0] SEL = 3'h5;

  pot_link_if pot_link_if_inst ();

  pot_host #(.NVW_CYCLES(20)) pot_host_inst (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .link        (pot_link_if_inst),
    .req_valid_i (req_valid_i),
    .req_ready_o (req_ready_o),
    .req_read_i  (req_read_i),
    .req_sel_i   (req_sel_i),
    .req_loc_i   (req_loc_i),
    .req_data_i  (req_data_i),
    .req_count_i (req_count_i),
    .rd_data_o   (rd_data_o),
    .rd_valid_o  (rd_valid_o),
    .done_o      (done_o),
    .nack_o      (nack_o)
  );

  pot_dev #(.NVW_CYCLES(20)) pot_dev_inst (
    .core_clk_i         (core_clk_i),
    .reset_i            (reset_i),
    .link               (pot_link_if_inst),
    .addr_select_pin2_i (SEL[2]),
    .addr_select_pin1_i (SEL[1]),
    .addr_select_pin0_i (SEL[0]),
    .wr_protect_n_i     (wr_protect_n_i),
    .wiper0_o           (wiper0_o),
    .wiper1_o           (wiper1_o),
    .nv_busy_o          (nv_busy_o)
  );

  pot_link_checker pot_link_checker_inst (
    .core_clk_i    (core_clk_i),
    .reset_i       (reset_i),
    .scl           (pot_link_if_inst.scl),
    .sda           (pot_link_if_inst.sda),
    .host_sda_o    (pot_link_if_inst.host_sda_o),
    .host_sda_oe_n (pot_link_if_inst.host_sda_oe_n),
    .dev_sda_o     (pot_link_if_inst.dev_sda_o),
    .dev_sda_oe_n  (pot_link_if_inst.dev_sda_oe_n)
  );

  always #20 core_clk_i = !core_clk_i;

  task automatic end_sim();
    $display("counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one whole transaction; bounded wait for done, gathers read bytes
  task automatic xfer(input logic rd, input logic [2:0] sel,
                      input logic [3:0] loc, input byte_t d,
                      input logic [3:0] cnt);
    int n;
    rx.delete();
    saw_busy = 1'b0;
    n = 0;
    @(posedge core_clk_i);
    #1;
    `CHK("req_ready", 1'b1, req_ready_o)
    req_valid_i = 1'b1;
    req_read_i  = rd;
    req_sel_i   = sel;
    req_loc_i   = loc;
    req_data_i  = d;
    req_count_i = cnt;
    @(posedge core_clk_i);
    #1;
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 4000)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (rd_valid_o === 1'b1)
        rx.push_back(rd_data_o);
      if (nv_busy_o === 1'b1)
        saw_busy = 1'b1;
    end
    `CHK("done", 1'b1, done_o)
  endtask

  task automatic wr(input logic [3:0] loc, input byte_t d,
                    input logic exp_nack, input logic exp_busy);
    xfer(1'b0, SEL, loc, d, 4'h1);
    `CHK("nack", exp_nack, nack_o)
    `CHK("store_cycle", exp_busy, saw_busy)
    `CHK("nv_busy_after", 1'b0, nv_busy_o)
  endtask

  task automatic rd(input logic [3:0] loc, input byte_t e[$]);
    xfer(1'b1, SEL, loc, 8'h00, 4'(e.size()));
    `CHK("nack", 1'b0, nack_o)
    `CHK("rx_count", e.size(), rx.size())
    for (int i = 0; i < e.size() && i < rx.size(); i++)
      `CHK("rx_byte", e[i], rx[i])
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      $display("MISMATCH timeout exp %h got %h", 1'b0, 1'b1);
      end_sim();
    end
  end

  initial
  begin
    core_clk_i = 1'b0;
    reset_i = 1'b1;
    wr_protect_n_i = 1'b1;
    req_valid_i = 1'b0;
    req_read_i = 1'b0;
    req_sel_i = 3'h0;
    req_loc_i = 4'h0;
    req_data_i = 8'h00;
    req_count_i = 4'h0;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (6) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK("wiper0", 8'h80, wiper0_o)
    `CHK("wiper1", 8'h80, wiper1_o)
    `CHK("nv_busy", 1'b0, nv_busy_o)
    $display("test reset done");
    // stored 7, control byte, then wrap to stored 0
    rd(4'h7, '{8'h00, 8'h00, 8'h80});
    $display("test read wrap done");
    wr(4'h0, 8'h3c, 1'b0, 1'b1);
    `CHK("wiper0", 8'h3c, wiper0_o)
    rd(4'h0, '{8'h3c, 8'h80});
    $display("test stored write done");
    wr(4'h8, 8'h80, 1'b0, 1'b0);
    wr(4'h1, 8'h5a, 1'b0, 1'b0);
    `CHK("wiper1", 8'h5a, wiper1_o)
    rd(4'h0, '{8'h3c, 8'h5a});
    $display("test volatile write done");
    wr_protect_n_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    wr(4'h1, 8'h11, 1'b1, 1'b0);
    `CHK("wiper1", 8'h5a, wiper1_o)
    wr_protect_n_i = 1'b1;
    $display("test protect done");
    xfer(1'b0, 3'h2, 4'h1, 8'h22, 4'h1);
    `CHK("nack", 1'b1, nack_o)
    `CHK("wiper1", 8'h5a, wiper1_o)
    xfer(1'b1, 3'h4, 4'h0, 8'h00, 4'h1);
    `CHK("nack", 1'b1, nack_o)
    `CHK("rx_count", 0, rx.size())
    wr(4'h9, 8'h33, 1'b1, 1'b0);
    $display("test refusals done");
    wr(4'h8, 8'h00, 1'b0, 1'b0);
    wr(4'h6, 8'ha5, 1'b0, 1'b1);
    rd(4'h6, '{8'ha5});
    rd(4'h1, '{8'h80});
    $display("test store range done");
    end_sim();
  end
endmodule
